// ==== design/ext_wakeup_soft_irq_defines.svh ====
// Register offsets, field positions and reset values of the request source block
`ifndef EXT_WAKEUP_SOFT_IRQ_DEFINES_SVH
`define EXT_WAKEUP_SOFT_IRQ_DEFINES_SVH

`define NUM_CH 8
`define ADDR_W 8
// Register byte offsets
`define OFS_DETECT_LEVEL_SELECT 8'h00
`define OFS_EXT_REQ_ENABLE 8'h04
`define OFS_EXT_REQ_FLAG 8'h08
`define OFS_IRQ_LEVEL_CTRL 8'h0C
`define OFS_WAKE_ENABLE 8'h10
`define OFS_WAKE_FLAG 8'h14
`define OFS_SOFT_IRQ 8'h18
`define OFS_IRQ_STATUS 8'h1C
`define OFS_IRQ_MASK 8'h20
// Field positions
`define DLS_W 16
`define CTRL_TSE_BIT 0
`define CTRL_DTP_BIT 1
`define WAKE_EN_BIT 0
`define WAKE_FLAG_BIT 0
`define SOFT_IRQ_BIT 0
`define ST_EXT_BIT 0
`define ST_WAKE_BIT 1
`define ST_SOFT_BIT 2
`define ST_W 3
// Detection codes, two bits per channel
`define DET_LOW 2'h0
`define DET_HIGH 2'h1
`define DET_RISE 2'h2
`define DET_FALL 2'h3
// Reset values
`define RST_DLS 16'h0000
`define RST_BYTE 8'h00
`define RST_CTRL 2'h0
`define RST_ST 3'h0
`define RST_PIN_IDLE 8'hFF

`endif

// ==== design/ext_wakeup_soft_irq_pkg.sv ====
// Types shared by the request source block modules
package ext_wakeup_soft_irq_pkg;
  typedef logic [1:0] det_mode_t;
  typedef logic [7:0] chan_t;
endpackage : ext_wakeup_soft_irq_pkg

// ==== design/pin_detect_if.sv ====
// Carrier between the pin detector and the register core
`timescale 1ns/1ns
interface pin_detect_if;
  import ext_wakeup_soft_irq_pkg::*;
  logic [15:0] det_mode;
  logic dtp_mode;
  chan_t ext_hit;
  chan_t wake_low;
  modport detector (input det_mode, input dtp_mode, output ext_hit, output wake_low);
  modport core (output det_mode, output dtp_mode, input ext_hit, input wake_low);
endinterface : pin_detect_if

// ==== design/pin_detector.sv ====
// Two-stage pin synchroniser and per-channel level or edge detector
`timescale 1ns/1ns
`include "ext_wakeup_soft_irq_defines.svh"
module pin_detector
  import ext_wakeup_soft_irq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] ext_req_in,
  input wire logic [7:0] wake_in,
  pin_detect_if.detector det
);
  typedef struct packed {
    chan_t ext_s1;
    chan_t ext_s2;
    chan_t ext_prev;
    chan_t wake_s1;
    chan_t wake_s2;
  } sync_s;

  sync_s st_q;
  sync_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.ext_s1 = ext_req_in;
    st_d.ext_s2 = st_q.ext_s1;
    st_d.ext_prev = st_q.ext_s2;
    st_d.wake_s1 = wake_in;
    st_d.wake_s2 = st_q.wake_s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Stages start at the idle high level, so release shows no false low or edge
      st_q.ext_s1 <= `RST_PIN_IDLE;
      st_q.ext_s2 <= `RST_PIN_IDLE;
      st_q.ext_prev <= `RST_PIN_IDLE;
      st_q.wake_s1 <= `RST_PIN_IDLE;
      st_q.wake_s2 <= `RST_PIN_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Detection per channel
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < `NUM_CH; i++) begin : g_ch
      det_mode_t m;
      logic hit;
      assign m = det.det_mode[2*i+1:2*i];
      // Edge codes fall back to their level when transfer requests use the pin
      always_comb begin
        case (m)
          `DET_LOW: hit = !st_q.ext_s2[i];
          `DET_HIGH: hit = st_q.ext_s2[i];
          `DET_RISE: hit = det.dtp_mode ? st_q.ext_s2[i]
                           : (st_q.ext_s2[i] && !st_q.ext_prev[i]);
          default: hit = det.dtp_mode ? !st_q.ext_s2[i]
                         : (!st_q.ext_s2[i] && st_q.ext_prev[i]);
        endcase
      end
      assign det.ext_hit[i] = hit;
      assign det.wake_low[i] = !st_q.wake_s2[i];
    end
  endgenerate
endmodule : pin_detector

// ==== design/apb_slave_port.sv ====
// APB slave front end with a one-cycle access phase
`timescale 1ns/1ns
`include "ext_wakeup_soft_irq_defines.svh"
module apb_slave_port (
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  output logic pready,
  output logic pslverr,
  input wire logic addr_ok,
  output logic wr_en,
  output logic rd_en
);
  // Zero wait state: every access ends in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;
endmodule : apb_slave_port

// ==== design/ext_wakeup_soft_irq.sv ====
// External request, wakeup and software interrupt source block
`timescale 1ns/1ns
`include "ext_wakeup_soft_irq_defines.svh"
module ext_wakeup_soft_irq
  import ext_wakeup_soft_irq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] ext_req_in,
  input wire logic [7:0] wake_in,
  input wire logic hw_standby,
  output logic [7:0] ext_irq_req,
  output logic [7:0] ext_transfer_req,
  output logic wake_irq_req,
  output logic standby_wakeup,
  output logic soft_irq_req,
  output logic irq
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0] detect_level_select;
    chan_t ext_req_enable_reg;
    chan_t ext_req_flag_reg;
    logic transfer_service_enable;
    logic pin_transfer_request;
    logic wake_enable_reg;
    logic wake_flag_reg;
    logic soft_irq_bit;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [31:0] rdata;
    chan_t ext_irq;
    chan_t ext_xfer;
    logic wake_irq;
    logic wake_exit;
  } core_s;

  core_s st_q;
  core_s st_d;

  pin_detect_if det_if ();
  logic addr_ok;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_mux;
  chan_t ext_pend;
  logic wake_any;
  logic [2:0] ev;

  // ****************************************
  // Submodules
  // ****************************************
  pin_detector u_pins (
    .pclk(pclk),
    .presetn(presetn),
    .ext_req_in(ext_req_in),
    .wake_in(wake_in),
    .det(det_if.detector)
  );

  apb_slave_port u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pready(pready),
    .pslverr(pslverr),
    .addr_ok(addr_ok),
    .wr_en(wr_en),
    .rd_en(rd_en)
  );

  assign det_if.det_mode = st_q.detect_level_select;
  assign det_if.dtp_mode = st_q.pin_transfer_request;

  // ****************************************
  // Address decode and read mux
  // ****************************************
  always_comb begin
    addr_ok = 1'b1;
    rd_mux = '0;
    if (paddr == `OFS_DETECT_LEVEL_SELECT) begin
      rd_mux[`DLS_W-1:0] = st_q.detect_level_select;
    end else if (paddr == `OFS_EXT_REQ_ENABLE) begin
      rd_mux[7:0] = st_q.ext_req_enable_reg;
    end else if (paddr == `OFS_EXT_REQ_FLAG) begin
      rd_mux[7:0] = st_q.ext_req_flag_reg;
    end else if (paddr == `OFS_IRQ_LEVEL_CTRL) begin
      rd_mux[`CTRL_TSE_BIT] = st_q.transfer_service_enable;
      rd_mux[`CTRL_DTP_BIT] = st_q.pin_transfer_request;
    end else if (paddr == `OFS_WAKE_ENABLE) begin
      rd_mux[`WAKE_EN_BIT] = st_q.wake_enable_reg;
    end else if (paddr == `OFS_WAKE_FLAG) begin
      rd_mux[`WAKE_FLAG_BIT] = st_q.wake_flag_reg;
    end else if (paddr == `OFS_SOFT_IRQ) begin
      rd_mux[`SOFT_IRQ_BIT] = st_q.soft_irq_bit;
    end else if (paddr == `OFS_IRQ_STATUS) begin
      rd_mux[`ST_W-1:0] = st_q.irq_status;
    end else if (paddr == `OFS_IRQ_MASK) begin
      rd_mux[`ST_W-1:0] = st_q.irq_mask;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  // Flags follow the same write-one-to-clear scheme; set wins a same-cycle clear
  always_comb begin
    st_d = st_q;
    ext_pend = st_q.ext_req_flag_reg | det_if.ext_hit;
    if (wr_en && paddr == `OFS_EXT_REQ_FLAG) begin
      ext_pend = (st_q.ext_req_flag_reg & ~pwdata[7:0]) | det_if.ext_hit;
    end
    st_d.ext_req_flag_reg = ext_pend;
    wake_any = |(det_if.wake_low) && st_q.wake_enable_reg;
    st_d.wake_flag_reg = st_q.wake_flag_reg | wake_any;
    if (wr_en && paddr == `OFS_WAKE_FLAG && pwdata[`WAKE_FLAG_BIT]) begin
      st_d.wake_flag_reg = wake_any;
    end
    ev = {1'b0, wake_any, |det_if.ext_hit};
    st_d.irq_status = st_q.irq_status | ev;
    if (wr_en && paddr == `OFS_IRQ_STATUS) begin
      st_d.irq_status = (st_q.irq_status & ~pwdata[`ST_W-1:0]) | ev;
    end
    if (wr_en) begin
      if (paddr == `OFS_DETECT_LEVEL_SELECT) begin
        st_d.detect_level_select = pwdata[`DLS_W-1:0];
      end else if (paddr == `OFS_EXT_REQ_ENABLE) begin
        st_d.ext_req_enable_reg = pwdata[7:0];
      end else if (paddr == `OFS_IRQ_LEVEL_CTRL) begin
        st_d.transfer_service_enable = pwdata[`CTRL_TSE_BIT];
        st_d.pin_transfer_request = pwdata[`CTRL_DTP_BIT];
      end else if (paddr == `OFS_WAKE_ENABLE) begin
        st_d.wake_enable_reg = pwdata[`WAKE_EN_BIT];
      end else if (paddr == `OFS_SOFT_IRQ) begin
        st_d.soft_irq_bit = pwdata[`SOFT_IRQ_BIT];
      end else if (paddr == `OFS_IRQ_MASK) begin
        st_d.irq_mask = pwdata[`ST_W-1:0];
      end
    end
    // The soft bit is its own status; it mirrors into the summary register
    st_d.irq_status[`ST_SOFT_BIT] = st_d.soft_irq_bit;
    // Requests toward the CPU from the latched flags, gated by enables
    st_d.ext_irq = (st_q.transfer_service_enable ? 8'h00 : 8'hFF)
                   & st_q.ext_req_flag_reg & st_q.ext_req_enable_reg;
    st_d.ext_xfer = (st_q.transfer_service_enable ? 8'hFF : 8'h00)
                    & st_q.ext_req_flag_reg & st_q.ext_req_enable_reg;
    st_d.wake_irq = st_q.wake_flag_reg && st_q.wake_enable_reg;
    st_d.wake_exit = st_q.wake_flag_reg && st_q.wake_enable_reg && !hw_standby;
    st_d.rdata = rd_en ? rd_mux : st_q.rdata;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = st_q.rdata;
  assign ext_irq_req = st_q.ext_irq;
  assign ext_transfer_req = st_q.ext_xfer;
  assign wake_irq_req = st_q.wake_irq;
  assign standby_wakeup = st_q.wake_exit;
  assign soft_irq_req = st_q.soft_irq_bit;
  assign irq = |(st_q.irq_status & st_q.irq_mask);

  // ****************************************
  // Checks
  // ****************************************
  property p_soft_set;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `OFS_SOFT_IRQ && pwdata[`SOFT_IRQ_BIT]) |=> soft_irq_req;
  endproperty
  a_soft_set: assert property (p_soft_set) else $error("soft irq not raised");

  property p_soft_clr;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `OFS_SOFT_IRQ && !pwdata[`SOFT_IRQ_BIT]) |=> !soft_irq_req;
  endproperty
  a_soft_clr: assert property (p_soft_clr) else $error("soft irq not withdrawn");

  property p_soft_hold;
    @(posedge pclk) disable iff (!presetn)
      (soft_irq_req && !(wr_en && paddr == `OFS_SOFT_IRQ)) |=> soft_irq_req;
  endproperty
  a_soft_hold: assert property (p_soft_hold) else $error("soft irq dropped");

  property p_flag_sticky;
    @(posedge pclk) disable iff (!presetn)
      (st_q.ext_req_flag_reg[0] && !(wr_en && paddr == `OFS_EXT_REQ_FLAG))
        |=> st_q.ext_req_flag_reg[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("ext flag lost");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
      det_if.ext_hit[3] |=> st_q.ext_req_flag_reg[3];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("ext flag not set");

  property p_ext_route;
    @(posedge pclk) disable iff (!presetn)
      (st_q.ext_req_flag_reg[1] && st_q.ext_req_enable_reg[1])
        |=> (ext_irq_req[1] != ext_transfer_req[1]);
  endproperty
  a_ext_route: assert property (p_ext_route) else $error("ext request not routed");

  property p_ext_gate;
    @(posedge pclk) disable iff (!presetn)
      !st_q.ext_req_enable_reg[2] |=> !ext_irq_req[2];
  endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("disabled channel requested");

  property p_wake_set;
    @(posedge pclk) disable iff (!presetn)
      (st_q.wake_enable_reg && !wake_in[5]) |=> ##2 st_q.wake_flag_reg;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake flag not set");

  property p_wake_gate;
    @(posedge pclk) disable iff (!presetn)
      !st_q.wake_enable_reg |=> !wake_irq_req;
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake irq while disabled");

  property p_hw_standby;
    @(posedge pclk) disable iff (!presetn)
      hw_standby |=> !standby_wakeup;
  endproperty
  a_hw_standby: assert property (p_hw_standby) else $error("wake from hw standby");

  property p_xfer_gate;
    @(posedge pclk) disable iff (!presetn)
      !st_q.ext_req_enable_reg[2] |=> !ext_transfer_req[2];
  endproperty
  a_xfer_gate: assert property (p_xfer_gate) else $error("disabled channel transfer");

  property p_handler_path;
    @(posedge pclk) disable iff (!presetn)
      (!st_q.transfer_service_enable && st_q.ext_req_flag_reg[0] && st_q.ext_req_enable_reg[0])
        |=> (ext_irq_req[0] && !ext_transfer_req[0]);
  endproperty
  a_handler_path: assert property (p_handler_path) else $error("handler path missed");

  property p_auto_path;
    @(posedge pclk) disable iff (!presetn)
      (st_q.transfer_service_enable && st_q.ext_req_flag_reg[4] && st_q.ext_req_enable_reg[4])
        |=> (ext_transfer_req[4] && !ext_irq_req[4]);
  endproperty
  a_auto_path: assert property (p_auto_path) else $error("transfer path missed");

  property p_flag_clear;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `OFS_EXT_REQ_FLAG && pwdata[5] && !det_if.ext_hit[5])
        |=> !st_q.ext_req_flag_reg[5];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("ext flag not cleared");

  property p_wake_sticky;
    @(posedge pclk) disable iff (!presetn)
      (st_q.wake_flag_reg && !(wr_en && paddr == `OFS_WAKE_FLAG)) |=> st_q.wake_flag_reg;
  endproperty
  a_wake_sticky: assert property (p_wake_sticky) else $error("wake flag lost");

  property p_wake_clear;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == `OFS_WAKE_FLAG && pwdata[`WAKE_FLAG_BIT] && !wake_any)
        |=> !st_q.wake_flag_reg;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake flag not cleared");

  property p_wake_irq;
    @(posedge pclk) disable iff (!presetn)
      (st_q.wake_flag_reg && st_q.wake_enable_reg) |=> wake_irq_req;
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake irq not raised");

  property p_wake_exit;
    @(posedge pclk) disable iff (!presetn)
      (st_q.wake_flag_reg && st_q.wake_enable_reg && !hw_standby) |=> standby_wakeup;
  endproperty
  a_wake_exit: assert property (p_wake_exit) else $error("standby exit missed");

  property p_exit_needs_req;
    @(posedge pclk) disable iff (!presetn)
      standby_wakeup |-> wake_irq_req;
  endproperty
  a_exit_needs_req: assert property (p_exit_needs_req) else $error("exit without wake");

  property p_soft_status;
    @(posedge pclk) disable iff (!presetn)
      soft_irq_req |-> st_q.irq_status[`ST_SOFT_BIT];
  endproperty
  a_soft_status: assert property (p_soft_status) else $error("soft status missing");

  property p_irq_ext;
    @(posedge pclk) disable iff (!presetn)
      (st_q.irq_status[`ST_EXT_BIT] && st_q.irq_mask[`ST_EXT_BIT]) |-> irq;
  endproperty
  a_irq_ext: assert property (p_irq_ext) else $error("ext summary irq missing");

  property p_status_set;
    @(posedge pclk) disable iff (!presetn)
      (|det_if.ext_hit) |=> st_q.irq_status[`ST_EXT_BIT];
  endproperty
  a_status_set: assert property (p_status_set) else $error("ext status not set");

  property p_rdata_hold;
    @(posedge pclk) disable iff (!presetn)
      !rd_en |=> $stable(prdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule : ext_wakeup_soft_irq

// ==== sim/pin_source.sv ====
// Model of the external devices that drive the request and wakeup pins
`timescale 1ns/1ns
module pin_source (
  input wire logic pclk,
  input wire logic slow,
  input wire logic [7:0] ext_level,
  input wire logic [7:0] wake_low,
  output logic [7:0] ext_req_in,
  output logic [7:0] wake_in
);
  logic [7:0] ext_q;
  logic [7:0] wake_q;

  // A slow device reaches its pins one clock later than a prompt one
  always_ff @(posedge pclk) begin
    ext_q <= ext_level;
    wake_q <= ~wake_low;
    ext_req_in <= slow ? ext_q : ext_level;
    // A released wakeup line floats up through its pull-up
    wake_in <= slow ? wake_q : ~wake_low;
  end
endmodule : pin_source

// ==== sim/tb.sv ====
// Self-checking bench for the request source block
`timescale 1ns/1ns
`include "ext_wakeup_soft_irq_defines.svh"
module tb;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic hw_standby = 1'h0;
  logic slow = 1'h0;
  logic [7:0] paddr = '0;
  logic [7:0] ext_level = 8'hFF;
  logic [7:0] wake_low = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, wake_irq_req, standby_wakeup, soft_irq_req, irq;
  logic [7:0] ext_req_in, wake_in, ext_irq_req, ext_transfer_req, r, e, s;
  logic [31:0] seed = 32'hB7E2E518;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;

  ext_wakeup_soft_irq i_ext_wakeup_soft_irq (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_req_in(ext_req_in), .wake_in(wake_in),
    .hw_standby(hw_standby), .ext_irq_req(ext_irq_req), .ext_transfer_req(ext_transfer_req),
    .wake_irq_req(wake_irq_req), .standby_wakeup(standby_wakeup),
    .soft_irq_req(soft_irq_req), .irq(irq));
  pin_source i_pin_source (.pclk(pclk), .slow(slow), .ext_level(ext_level),
    .wake_low(wake_low), .ext_req_in(ext_req_in), .wake_in(wake_in));

  initial begin
    forever #50 pclk = ~pclk;
  end

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'h0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_rd

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t pins %h expected %h", $time, got, exp);
    end
  endtask : chk_pin

  // The master never assumes the answer time, it waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, '0);
    chk_rd(rd, exp);
  endtask : rdc

  task automatic tick;
    repeat (6) @(posedge pclk);
  endtask : tick

  task automatic pins(input logic [7:0] lvl, input logic [7:0] wl);
    @(posedge pclk);
    ext_level <= lvl;
    wake_low <= wl;
    repeat (8) @(posedge pclk);
  endtask : pins

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      complete_run;
    end
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    for (logic [7:0] a = 8'h00; a <= 8'h20; a += 8'h04) rdc(a, '0);
    apb(1'h0, 8'h24, '0);
    chk_rd(rd, '0);
    chk_pin({7'h0, err}, 8'h01);
    // Start level makes each mode see exactly the bits of r
    for (int m = 0; m < 4; m++) begin
      seed = lfsr(seed);
      r = seed[7:0];
      e = seed[15:8];
      s = (m == 0 || m == 3) ? 8'hFF : 8'h00;
      pins(s, '0);
      slow <= seed[16];
      wr(`OFS_DETECT_LEVEL_SELECT, {16'h0, {8{m[1:0]}}});
      wr(`OFS_EXT_REQ_ENABLE, {24'h0, e});
      wr(`OFS_IRQ_LEVEL_CTRL, {31'h0, m[0]});
      wr(`OFS_EXT_REQ_FLAG, 32'hFF);
      pins(s ^ r, '0);
      rdc(`OFS_EXT_REQ_FLAG, {24'h0, r});
      chk_pin(ext_irq_req, m[0] ? 8'h00 : r & e);
      chk_pin(ext_transfer_req, m[0] ? r & e : 8'h00);
      wr(`OFS_EXT_REQ_FLAG, 32'hFF);
      rdc(`OFS_EXT_REQ_FLAG, {24'h0, m < 2 ? r : 8'h00});
      wr(`OFS_IRQ_LEVEL_CTRL, 32'h2);
      tick;
      rdc(`OFS_EXT_REQ_FLAG, {24'h0, r});
    end
    rdc(`OFS_IRQ_STATUS, 32'h1);
    wr(`OFS_IRQ_MASK, 32'h7);
    tick;
    chk_pin({7'h0, irq}, 8'h01);
    pins(8'hFF, '0);
    wr(`OFS_IRQ_STATUS, 32'h1);
    tick;
    chk_pin({7'h0, irq}, 8'h00);
    wr(`OFS_WAKE_ENABLE, 32'h0);
    pins(8'hFF, 8'h10);
    chk_pin({6'h0, wake_irq_req, standby_wakeup}, 8'h00);
    pins(8'hFF, '0);
    wr(`OFS_WAKE_FLAG, 32'h1);
    wr(`OFS_IRQ_STATUS, 32'h2);
    wr(`OFS_WAKE_ENABLE, 32'h1);
    seed = lfsr(seed);
    pins(8'hFF, 8'h01 << seed[2:0]);
    pins(8'hFF, '0);
    rdc(`OFS_WAKE_FLAG, 32'h1);
    chk_pin({6'h0, wake_irq_req, standby_wakeup}, 8'h03);
    @(posedge pclk);
    hw_standby <= 1'h1;
    tick;
    chk_pin({6'h0, wake_irq_req, standby_wakeup}, 8'h02);
    wr(`OFS_IRQ_MASK, 32'h2);
    tick;
    chk_pin({7'h0, irq}, 8'h01);
    wr(`OFS_WAKE_FLAG, 32'h1);
    wr(`OFS_IRQ_STATUS, 32'h2);
    rdc(`OFS_WAKE_FLAG, '0);
    tick;
    chk_pin({6'h0, wake_irq_req, irq}, 8'h00);
    wr(`OFS_IRQ_MASK, 32'h4);
    wr(`OFS_SOFT_IRQ, 32'h1);
    rdc(`OFS_SOFT_IRQ, 32'h1);
    tick;
    chk_pin({6'h0, soft_irq_req, irq}, 8'h03);
    wr(`OFS_IRQ_MASK, 32'h0);
    tick;
    chk_pin({6'h0, soft_irq_req, irq}, 8'h02);
    wr(`OFS_SOFT_IRQ, 32'h0);
    rdc(`OFS_SOFT_IRQ, '0);
    tick;
    chk_pin({7'h0, soft_irq_req}, 8'h00);
    complete_run;
  end
endmodule : tb
